// [spm_pkg.sv]
// Package with constants and types for the six-pin port function multiplexer.
// Functional notes
// - Six pins, each with own direction bit.
// - Pins 0..3 offer pull-high and pull-low inputs.
// - All pins offer pull-high and open-drain mode.
// - Input threshold selectable: TTL, CMOS, non-Schmitt.
// - Pin 0 external interrupt needs select and enable.
// - Infrared mode puts carrier on pin one.
// - Pin two can clock the timers externally.
// - Pin two can output pulse-width or buzzer.
// - Pin three never drives high.
// - Pin three low resets device when selected.
// - Pin three pull-high under program control.
// - Pin four can output instruction clock.
// - Low crystal takes pins four and five.
// - Pins 0..2 have six drive strength levels.
// - Pins 0..3 become programming pads when programming.
// - Halt wakes on watchdog, port change, external interrupt.
// - Standby also wakes on timer events.
package spm_pkg;
  localparam int unsigned PIN_COUNT    = 6;
  localparam int unsigned PULL_LOW_CNT = 4;
  localparam int unsigned HS_PIN_CNT   = 3;
  localparam int unsigned PIN_EXTIRQ   = 0;
  localparam int unsigned PIN_IR       = 1;
  localparam int unsigned PIN_TMRCLK   = 2;
  localparam int unsigned PIN_RESET    = 3;
  localparam int unsigned PIN_XOUT     = 4;
  localparam int unsigned PIN_XIN      = 5;
  localparam logic [2:0]  DRIVE_LEVELS = 3'h6;
  localparam logic [5:0]  PINS_RESET   = 6'h00;
  localparam logic [5:0]  DIR_RESET    = 6'h3F;
  typedef enum logic [1:0] {SPM_THR_TTL, SPM_THR_CMOS, SPM_THR_PLAIN} spm_thr_e;
  typedef enum logic [1:0] {SPM_PW_RUN, SPM_PW_STANDBY, SPM_PW_HALT} spm_pwr_e;
  typedef enum logic [1:0] {SPM_P2_PORT, SPM_P2_PWM, SPM_P2_BUZZ} spm_p2_e;
endpackage : spm_pkg

// [spm_sync.sv]
// Two-stage synchroniser for the pin inputs.
`timescale 1ns/1ps
module spm_sync #(
  parameter int unsigned W = 6
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule : spm_sync

// [spm_port_mux.sv]
// Pin direction, pull, drive and alternate function multiplexer for the six-pin port.
`timescale 1ns/1ps
module spm_port_mux (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [5:0]        port_data_i,
  input  wire logic [5:0]        port_dir_in_i,
  input  wire logic [5:0]        pull_high_en_i,
  input  wire logic [3:0]        pull_low_en_i,
  input  wire logic [5:0]        open_drain_en_i,
  input  wire spm_pkg::spm_thr_e threshold_sel_i,
  input  wire logic [8:0]        drive_level_i,
  input  wire logic              external_irq_pin_select_i,
  input  wire logic              external_irq_enable_i,
  input  wire logic              ir_mode_en_i,
  input  wire logic              ir_carrier_i,
  input  wire logic              timer_clk_pin_en_i,
  input  wire spm_pkg::spm_p2_e  pin2_out_sel_i,
  input  wire logic              pulse_width_output_i,
  input  wire logic              buzzer_output_i,
  input  wire logic              reset_pin_en_i,
  input  wire logic              instr_clk_out_en_i,
  input  wire logic              instr_clk_i,
  input  wire logic              external_low_crystal_osc_i,
  input  wire logic              programming_mode_i,
  input  wire logic              programming_data_out_i,
  input  wire logic [5:0]        change_en_i,
  input  wire spm_pkg::spm_pwr_e power_mode_i,
  input  wire logic              wdt_timeout_i,
  input  wire logic              timer0_overflow_i,
  input  wire logic              timer1_underflow_i,
  input  wire logic [5:0]        port_pins_i,
  output logic [5:0]             port_pins_o,
  output logic [5:0]             port_pins_oe_n_o,
  output logic [5:0]             pull_high_on_o,
  output logic [3:0]             pull_low_on_o,
  output spm_pkg::spm_thr_e      threshold_o,
  output logic [8:0]             drive_level_o,
  output logic [5:0]             port_read_o,
  output logic                   external_irq_o,
  output logic                   timer_external_clock_in_o,
  output logic                   external_reset_input_n_o,
  output logic                   crystal_active_o,
  output logic                   programming_data_in_o,
  output logic                   programming_clock_o,
  output logic                   programming_voltage_o,
  output logic                   change_irq_o,
  output logic                   wake_o
);
  import spm_pkg::*;

  logic [5:0] pins_sync;
  logic [5:0] prev_ff;
  logic [5:0] pins_o_ff;
  logic [5:0] oe_n_ff;
  logic [5:0] ph_ff;
  logic [3:0] pl_ff;
  spm_thr_e   thr_ff;
  logic [8:0] drv_ff;
  logic [5:0] rd_ff;
  logic       eirq_ff;
  logic       tclk_ff;
  logic       rst_n_ff;
  logic       xtal_ff;
  logic       sdi_ff;
  logic       sck_ff;
  logic       vpp_ff;
  logic       chg_ff;
  logic       wake_ff;

  // Pin inputs pass two flip-flops before any logic reads them.
  spm_sync #(.W(PIN_COUNT)) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (port_pins_i),
    .q_o     (pins_sync)
  );

  // Per-pin alternate output selection; a peripheral overrides port data.
  logic       pin2_periph;
  logic       pin2_value;
  logic [5:0] alt_used;
  logic [5:0] alt_value;
  logic [5:0] out_value;
  logic [5:0] is_output;
  logic [5:0] drive_low_only;
  logic [5:0] pad_owned;
  assign pin2_periph = (pin2_out_sel_i != SPM_P2_PORT) && !timer_clk_pin_en_i;
  assign pin2_value  = (pin2_out_sel_i == SPM_P2_PWM) ? pulse_width_output_i
                                                      : buzzer_output_i;
  assign alt_used  = {1'b0, instr_clk_out_en_i, 1'b0, pin2_periph, ir_mode_en_i,
                      1'b0};
  assign alt_value = {1'b0, instr_clk_i, 1'b0, pin2_value, ir_carrier_i, 1'b0};
  assign out_value = (alt_used & alt_value) | (~alt_used & port_data_i);
  // Crystal pins and programming pads leave port function entirely.
  assign pad_owned = {{2{external_low_crystal_osc_i}}, 4'h0}
                   | {2'b00, {4{programming_mode_i}}};
  assign is_output = (~port_dir_in_i | alt_used) & ~pad_owned;
  assign drive_low_only = open_drain_en_i | 6'h08;

  // Pad drive: in open-drain, drive only a low; enable active low.
  logic [5:0] nxt_pins_o;
  logic [5:0] nxt_oe_n;
  always_comb begin
    nxt_pins_o = out_value;
    nxt_oe_n   = ~is_output;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (is_output[i] && drive_low_only[i] && out_value[i]) begin
        nxt_oe_n[i] = 1'b1;
      end
      if (nxt_oe_n[i]) begin
        nxt_pins_o[i] = 1'b0;
      end
    end
    // Programming data out owns pin one while programming.
    if (programming_mode_i) begin
      nxt_pins_o[PIN_IR] = programming_data_out_i;
      nxt_oe_n[PIN_IR]   = 1'b0;
    end
  end

  // Pulls apply to inputs only and never to pads taken by the crystal.
  logic [5:0] nxt_ph;
  logic [3:0] nxt_pl;
  assign nxt_ph = pull_high_en_i & ~is_output & ~pad_owned;
  assign nxt_pl = pull_low_en_i & ~is_output[3:0] & ~pad_owned[3:0];

  // Drive level codes above the top level are clamped to it.
  logic [8:0] nxt_drv;
  genvar g;
  generate
    for (g = 0; g < HS_PIN_CNT; g++) begin : g_drv
      assign nxt_drv[g*3 +: 3] = (drive_level_i[g*3 +: 3] >= DRIVE_LEVELS)
                               ? DRIVE_LEVELS - 3'h1 : drive_level_i[g*3 +: 3];
    end
  endgenerate

  // Alternate input functions from synchronised pins.
  logic nxt_eirq;
  logic nxt_tclk;
  logic nxt_rst_n;
  assign nxt_eirq  = external_irq_pin_select_i && external_irq_enable_i
                   && !programming_mode_i && pins_sync[PIN_EXTIRQ];
  assign nxt_tclk  = timer_clk_pin_en_i && pins_sync[PIN_TMRCLK];
  assign nxt_rst_n = !(reset_pin_en_i && !programming_mode_i
                       && !pins_sync[PIN_RESET]);

  // Change detector on enabled inputs versus previous sample.
  logic [5:0] chg_bits;
  logic       nxt_chg;
  assign chg_bits = (pins_sync ^ prev_ff) & change_en_i & ~is_output & ~pad_owned;
  assign nxt_chg  = |chg_bits;

  // Wake sources depend on the low-power mode.
  logic halt_src;
  logic stby_src;
  logic nxt_wake;
  assign halt_src = wdt_timeout_i || nxt_chg || nxt_eirq;
  assign stby_src = halt_src || timer0_overflow_i || timer1_underflow_i;
  assign nxt_wake = (power_mode_i == SPM_PW_HALT)    ? halt_src :
                    (power_mode_i == SPM_PW_STANDBY) ? stby_src : 1'b0;

  // Registered pad controls.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_o_ff <= PINS_RESET;
      oe_n_ff   <= DIR_RESET;
      ph_ff     <= '0;
      pl_ff     <= '0;
      thr_ff    <= SPM_THR_TTL;
      drv_ff    <= '0;
    end else begin
      pins_o_ff <= nxt_pins_o;
      oe_n_ff   <= nxt_oe_n;
      ph_ff     <= nxt_ph;
      pl_ff     <= nxt_pl;
      thr_ff    <= threshold_sel_i;
      drv_ff    <= nxt_drv;
    end
  end

  // Registered function and event outputs.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev_ff  <= '0;
      rd_ff    <= '0;
      eirq_ff  <= 1'b0;
      tclk_ff  <= 1'b0;
      rst_n_ff <= 1'b1;
      xtal_ff  <= 1'b0;
      sdi_ff   <= 1'b0;
      sck_ff   <= 1'b0;
      vpp_ff   <= 1'b0;
      chg_ff   <= 1'b0;
      wake_ff  <= 1'b0;
    end else begin
      prev_ff  <= pins_sync;
      rd_ff    <= pins_sync & ~pad_owned;
      eirq_ff  <= nxt_eirq;
      tclk_ff  <= nxt_tclk;
      rst_n_ff <= nxt_rst_n;
      xtal_ff  <= external_low_crystal_osc_i;
      sdi_ff   <= programming_mode_i && pins_sync[PIN_EXTIRQ];
      sck_ff   <= programming_mode_i && pins_sync[PIN_TMRCLK];
      vpp_ff   <= programming_mode_i && pins_sync[PIN_RESET];
      chg_ff   <= nxt_chg;
      wake_ff  <= nxt_wake;
    end
  end

  assign port_pins_o               = pins_o_ff;
  assign port_pins_oe_n_o          = oe_n_ff;
  assign pull_high_on_o            = ph_ff;
  assign pull_low_on_o             = pl_ff;
  assign threshold_o               = thr_ff;
  assign drive_level_o             = drv_ff;
  assign port_read_o               = rd_ff;
  assign external_irq_o            = eirq_ff;
  assign timer_external_clock_in_o = tclk_ff;
  assign external_reset_input_n_o  = rst_n_ff;
  assign crystal_active_o          = xtal_ff;
  assign programming_data_in_o     = sdi_ff;
  assign programming_clock_o       = sck_ff;
  assign programming_voltage_o     = vpp_ff;
  assign change_irq_o              = chg_ff;
  assign wake_o                    = wake_ff;

  // Checks on pad behaviour and events.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  pin3_nohigh_a: assert property (!oe_n_ff[PIN_RESET] |-> !pins_o_ff[PIN_RESET])
    else $error("pin three driven high");
  od_nohigh_a: assert property (
    !(!oe_n_ff[0] && pins_o_ff[0] && $past(open_drain_en_i[0]) && !$past(programming_mode_i)))
    else $error("open drain pin driven high");
  ir_carrier_a: assert property (ir_mode_en_i && !programming_mode_i && !open_drain_en_i[1]
    |=> !oe_n_ff[PIN_IR] && pins_o_ff[PIN_IR] == $past(ir_carrier_i))
    else $error("carrier not on pin one");
  ext_irq_a: assert property (!(external_irq_pin_select_i && external_irq_enable_i)
    |=> !external_irq_o)
    else $error("external interrupt without enable");
  reset_pin_a: assert property (reset_pin_en_i && !programming_mode_i
    && !port_pins_i[PIN_RESET] [*4] |-> !external_reset_input_n_o)
    else $error("reset pin low did not reset");
  halt_wake_a: assert property (power_mode_i == SPM_PW_HALT && !wdt_timeout_i
    && !nxt_chg && !nxt_eirq |=> !wake_o)
    else $error("halt woke on timer event");
  stby_wake_a: assert property (power_mode_i == SPM_PW_STANDBY && timer0_overflow_i
    |=> wake_o)
    else $error("standby missed timer wake");
  xtal_pads_a: assert property (external_low_crystal_osc_i |=> oe_n_ff[5:4] == 2'b11
    && ph_ff[5:4] == 2'b00)
    else $error("crystal pins still in port use");
  drv_clamp_a: assert property (drive_level_o[2:0] < DRIVE_LEVELS)
    else $error("drive level out of range");
  pull_low_a: assert property (!port_dir_in_i[0] && !programming_mode_i |=> !pl_ff[0])
    else $error("pull low on output");

  chg_c: cover property (change_irq_o);
  wake_c: cover property (wake_o && power_mode_i == SPM_PW_HALT);
  pwm_c: cover property (pin2_out_sel_i == SPM_P2_PWM && !oe_n_ff[PIN_TMRCLK]);
  rst_c: cover property (!external_reset_input_n_o);
endmodule : spm_port_mux

// [spm_board.sv]
// Board model that resolves the six pad levels from every party on the pins.
`timescale 1ns/1ps
module spm_board (
  input  wire logic       clock_i,
  input  wire logic [5:0] dut_val_i,
  input  wire logic [5:0] dut_oe_n_i,
  input  wire logic [5:0] pull_high_i,
  input  wire logic [3:0] pull_low_i,
  input  wire logic [5:0] ext_en_i,
  input  wire logic [5:0] ext_val_i,
  output logic      [5:0] pad_o
);
  logic [5:0] float_ff = '0;
  logic [5:0] low_all;
  // Only the lower four pins have a pull-low resistor.
  assign low_all = {2'h0, pull_low_i};
  // An unpulled floating pin shows a pattern that changes every cycle.
  always_ff @(posedge clock_i) begin
    float_ff <= ~pad_o;
  end
  // Device drive wins, then the outside driver, then the resistors.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!dut_oe_n_i[i]) pad_o[i] = dut_val_i[i];
      else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
      else if (pull_high_i[i]) pad_o[i] = 1'b1;
      else if (low_all[i]) pad_o[i] = 1'b0;
      else pad_o[i] = float_ff[i];
    end
  end
endmodule : spm_board

// [tb.sv]
// Self-checking testbench for the six-pin port function multiplexer.
`timescale 1ns/1ps
module tb;
  import spm_pkg::*;
  logic       clock_i = 1'b0;
  logic       rst_i   = 1'b1;
  logic [5:0] port_data_i, port_dir_in_i, pull_high_en_i, open_drain_en_i, change_en_i;
  logic [5:0] port_pins_i, port_pins_o, port_pins_oe_n_o, pull_high_on_o, port_read_o;
  logic [3:0] pull_low_en_i, pull_low_on_o;
  logic [8:0] drive_level_i, drive_level_o;
  logic [5:0] ext_en, ext_val;
  logic [1:0] e;
  spm_thr_e   threshold_sel_i, threshold_o;
  spm_p2_e    pin2_out_sel_i;
  spm_pwr_e   power_mode_i;
  logic external_irq_pin_select_i, external_irq_enable_i, ir_mode_en_i, ir_carrier_i;
  logic timer_clk_pin_en_i, pulse_width_output_i, buzzer_output_i, reset_pin_en_i;
  logic instr_clk_out_en_i, instr_clk_i, external_low_crystal_osc_i, programming_mode_i;
  logic programming_data_out_i, wdt_timeout_i, timer0_overflow_i, timer1_underflow_i;
  logic external_irq_o, timer_external_clock_in_o, external_reset_input_n_o, crystal_active_o;
  logic programming_data_in_o, programming_clock_o, programming_voltage_o, change_irq_o, wake_o;
  int   error_cnt, n_checks, cyc;

  spm_port_mux i_dut (.clock_i, .rst_i, .port_data_i, .port_dir_in_i, .pull_high_en_i,
    .pull_low_en_i, .open_drain_en_i, .threshold_sel_i, .drive_level_i,
    .external_irq_pin_select_i, .external_irq_enable_i, .ir_mode_en_i, .ir_carrier_i,
    .timer_clk_pin_en_i, .pin2_out_sel_i, .pulse_width_output_i, .buzzer_output_i,
    .reset_pin_en_i, .instr_clk_out_en_i, .instr_clk_i, .external_low_crystal_osc_i,
    .programming_mode_i, .programming_data_out_i, .change_en_i, .power_mode_i,
    .wdt_timeout_i, .timer0_overflow_i, .timer1_underflow_i, .port_pins_i, .port_pins_o,
    .port_pins_oe_n_o, .pull_high_on_o, .pull_low_on_o, .threshold_o, .drive_level_o,
    .port_read_o, .external_irq_o, .timer_external_clock_in_o, .external_reset_input_n_o,
    .crystal_active_o, .programming_data_in_o, .programming_clock_o,
    .programming_voltage_o, .change_irq_o, .wake_o);

  spm_board i_board (.clock_i(clock_i), .dut_val_i(port_pins_o), .dut_oe_n_i(port_pins_oe_n_o),
    .pull_high_i(pull_high_on_o), .pull_low_i(pull_low_on_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_o(port_pins_i));

  // The clock toggles every half period of 5 ns.
  always #5 clock_i = ~clock_i;

  // A hang is cut short after a fixed number of cycles.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits n edges, then moves just past the last one.
  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : settle

  // Each strength code above five is clamped to five.
  function automatic logic [8:0] exp_drive(input logic [8:0] c);
    for (int k = 0; k < 3; k++) if (c[3*k+:3] > 3'h5) c[3*k+:3] = 3'h5;
    return c;
  endfunction : exp_drive

  // Returns the drive flag and the level expected on one pin.
  function automatic logic [1:0] exp_pin(input int i);
    logic v, drv;
    v = port_data_i[i];
    if (i == 1 && ir_mode_en_i) v = ir_carrier_i;
    if (i == 2 && !timer_clk_pin_en_i && pin2_out_sel_i == SPM_P2_PWM) v = pulse_width_output_i;
    if (i == 2 && !timer_clk_pin_en_i && pin2_out_sel_i == SPM_P2_BUZZ) v = buzzer_output_i;
    if (i == 4 && instr_clk_out_en_i) v = instr_clk_i;
    drv = !port_dir_in_i[i] && !((open_drain_en_i[i] || i == 3) && v);
    if (i > 3 && external_low_crystal_osc_i) drv = 1'b0;
    return {drv, v};
  endfunction : exp_pin

  // Main sequence: reset, random pad traffic, pin inputs, crystal, programming, wake.
  initial begin
    {port_data_i, pull_high_en_i, open_drain_en_i, change_en_i, pull_low_en_i} = '0;
    {drive_level_i, ext_en, ext_val} = '0;
    port_dir_in_i = 6'h3F;
    threshold_sel_i = SPM_THR_TTL;
    pin2_out_sel_i = SPM_P2_PORT;
    power_mode_i = SPM_PW_RUN;
    {external_irq_pin_select_i, external_irq_enable_i, ir_mode_en_i, ir_carrier_i} = 4'h0;
    {timer_clk_pin_en_i, pulse_width_output_i, buzzer_output_i, reset_pin_en_i} = 4'h0;
    {instr_clk_out_en_i, instr_clk_i, external_low_crystal_osc_i, programming_mode_i} = 4'h0;
    {programming_data_out_i, wdt_timeout_i, timer0_overflow_i, timer1_underflow_i} = 4'h0;
    void'($urandom(83814));
    settle(19);
    chk(port_pins_oe_n_o, 6'h3F);
    chk(pull_high_on_o, 6'h00);
    chk(external_reset_input_n_o, 1'b1);
    settle(1);
    rst_i = 1'b0;
    for (int n = 0; n < 300; n++) begin
      {port_data_i, port_dir_in_i, pull_high_en_i, open_drain_en_i} = 24'($urandom);
      {pull_low_en_i, drive_level_i, ext_val} = 19'($urandom);
      threshold_sel_i = spm_thr_e'($urandom % 3);
      pin2_out_sel_i = spm_p2_e'($urandom % 3);
      {ir_mode_en_i, ir_carrier_i, timer_clk_pin_en_i, pulse_width_output_i} = 4'($urandom);
      {buzzer_output_i, instr_clk_out_en_i, instr_clk_i, external_low_crystal_osc_i} = 4'($urandom);
      if (ir_mode_en_i) port_dir_in_i[1] = 1'b0;
      if (!timer_clk_pin_en_i && pin2_out_sel_i != SPM_P2_PORT) port_dir_in_i[2] = 1'b0;
      if (instr_clk_out_en_i) port_dir_in_i[4] = 1'b0;
      ext_en = port_dir_in_i;
      settle(1);
      for (int i = 0; i < 6; i++) begin
        e = exp_pin(i);
        chk(port_pins_oe_n_o[i], !e[1]);
        if (e[1]) chk(port_pins_o[i], e[0]);
      end
      chk(pull_low_on_o, pull_low_en_i & port_dir_in_i[3:0]);
      chk(threshold_o, threshold_sel_i);
      chk(drive_level_o, exp_drive(drive_level_i));
    end
    {port_dir_in_i, ext_en} = 12'hFFF;
    {ir_mode_en_i, timer_clk_pin_en_i, instr_clk_out_en_i, external_low_crystal_osc_i} = 4'h0;
    pin2_out_sel_i = SPM_P2_PORT;
    for (int k = 0; k < 16; k++) begin
      {external_irq_pin_select_i, external_irq_enable_i, reset_pin_en_i} = 3'(k);
      timer_clk_pin_en_i = k[0];
      ext_val = 6'($urandom);
      ext_val[0] = k[3];
      ext_val[3] = k[3];
      settle(4);
      chk(port_read_o, ext_val);
      chk(external_irq_o, ext_val[0] & k[2] & k[1]);
      chk(external_reset_input_n_o, !(k[0] && !ext_val[3]));
      chk(timer_external_clock_in_o, ext_val[2] & k[0]);
    end
    {reset_pin_en_i, timer_clk_pin_en_i, external_irq_enable_i} = 3'h0;
    external_low_crystal_osc_i = 1'b1;
    settle(4);
    chk({crystal_active_o, port_read_o[5:4], port_pins_oe_n_o[5:4]}, 5'h13);
    external_low_crystal_osc_i = 1'b0;
    programming_mode_i = 1'b1;
    ext_en = 6'h3D;
    for (int k = 0; k < 4; k++) begin
      programming_data_out_i = k[0];
      ext_val = 6'($urandom);
      settle(4);
      chk({port_pins_oe_n_o[1], port_pins_o[1]}, {1'b0, k[0]});
      chk({programming_data_in_o, programming_clock_o, programming_voltage_o},
          {ext_val[0], ext_val[2], ext_val[3]});
    end
    programming_mode_i = 1'b0;
    ext_en = 6'h3F;
    settle(4);
    change_en_i = 6'h3F;
    ext_val[5] = ~ext_val[5];
    settle(3);
    chk(change_irq_o, 1'b1);
    settle(1);
    chk(change_irq_o, 1'b0);
    change_en_i = 6'h00;
    settle(1);
    for (int m = 0; m < 3; m++) for (int s = 0; s < 3; s++) begin
      power_mode_i = spm_pwr_e'(m);
      {wdt_timeout_i, timer0_overflow_i, timer1_underflow_i} = 3'h4 >> s;
      settle(1);
      {wdt_timeout_i, timer0_overflow_i, timer1_underflow_i} = 3'h0;
      chk(wake_o, (m == SPM_PW_HALT && s == 0) || m == SPM_PW_STANDBY);
      settle(1);
    end
    finish_test();
  end
endmodule : tb
